// >>> rwcc_pkg.sv
// Purpose: Shared constants and types for the radio wake and calibration configuration block.
// Assumes: 125 MHz reference clock, Avalon-MM slave with 32-bit data and byte addresses.
// Notes:   Ripple counter steps are made from the reference clock by a phase accumulator.
`default_nettype none

package rwcc_pkg;

    // Register byte addresses
    localparam logic [7:0] RWCC_CFG_OFFSET  = 8'h18;
    localparam logic [7:0] RWCC_STAT_OFFSET = 8'h1c;

    // Configuration field positions
    localparam int RWCC_KEEP_POS   = 0;
    localparam int RWCC_PIN_POS    = 1;
    localparam int RWCC_PO_LSB     = 2;
    localparam int RWCC_CAL_LSB    = 4;
    localparam logic [7:0] RWCC_CFG_RESET = 8'h04;
    localparam logic [7:0] RWCC_CFG_MASK  = 8'h3f;

    // Status field positions
    localparam int RWCC_ST_RDY_POS  = 0;
    localparam int RWCC_ST_XON_POS  = 1;
    localparam int RWCC_ST_PH_LSB   = 2;
    localparam int RWCC_ST_EXP_LSB  = 4;

    // Expiry counts per timeout setting
    localparam logic [8:0] RWCC_EXP_0 = 9'h001;
    localparam logic [8:0] RWCC_EXP_1 = 9'h010;
    localparam logic [8:0] RWCC_EXP_2 = 9'h040;
    localparam logic [8:0] RWCC_EXP_3 = 9'h100;

    // Timing of timeout setting 2
    localparam longint RWCC_CLK_PERIOD_NS = 8;
    localparam longint RWCC_T2_MIN_NS     = 149000;
    localparam longint RWCC_T2_MAX_NS     = 155000;
    localparam longint RWCC_T2_MID_NS     = (RWCC_T2_MIN_NS + RWCC_T2_MAX_NS) / 2;
    localparam longint RWCC_T2_STEPS      = 64 * 64;
    localparam int     RWCC_T2_MIN_CYC    = int'((RWCC_T2_MIN_NS + RWCC_CLK_PERIOD_NS - 1) / RWCC_CLK_PERIOD_NS);
    localparam int     RWCC_T2_MAX_CYC    = int'(RWCC_T2_MAX_NS / RWCC_CLK_PERIOD_NS);
    localparam int     RWCC_ACC_W         = 16;
    localparam logic [15:0] RWCC_STEP_INC = 16'(((longint'(1) << RWCC_ACC_W) * RWCC_T2_STEPS * RWCC_CLK_PERIOD_NS)
                                                / RWCC_T2_MID_NS);

    // Avalon-MM request
    typedef struct packed {
        logic        read;
        logic        write;
        logic [7:0]  address;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } rwcc_avs_req_type;

endpackage : rwcc_pkg

`default_nettype wire

// >>> rwcc_wake_cal.sv
// Purpose: Wake timeout, auto-calibration schedule, pin control and crystal keep-alive.
// Assumes: All inputs synchronous to ref_clk_i; event inputs are one-cycle pulses.
// Notes:   Avalon slave answers every access two edges after it starts.
`default_nettype none

module rwcc_wake_cal
    import rwcc_pkg::*;
#(
    parameter logic [15:0] STEP_INC = RWCC_STEP_INC
) (
    // Clock and reset
    input  wire logic              ref_clk_i,
    input  wire logic              arst_n_i,
    // Avalon-MM slave
    input  wire rwcc_avs_req_type  avs_req_i,
    output logic [31:0]            avs_readdata_o,
    output logic                   avs_waitrequest_o,
    // Radio state events
    input  wire logic              crystal_oscillator_stable_i,
    input  wire logic              sleep_i,
    input  wire logic              idle_to_active_i,
    input  wire logic              auto_idle_i,
    input  wire logic              cal_strobe_i,
    input  wire logic              pin_radio_req_i,
    // Results
    output logic                   crystal_enable_o,
    output logic                   chip_ready_low_o,
    output logic                   fs_cal_start_o,
    output logic                   pin_radio_req_o
);

    logic [7:0]  cfg_q;
    logic        ack_q;
    logic [31:0] rdata_q;
    logic [15:0] acc_q;
    logic [5:0]  ripple_q;
    logic [8:0]  expiry_q;
    logic [1:0]  phase_q;
    logic        ready_q;
    logic        cal_q;
    logic        pin_q;
    logic        step;
    logic        expire;
    logic [8:0]  target;
    logic [1:0]  cal_sel;
    logic        cal_d;
    logic        sel_cfg;
    logic        sel_stat;
    logic [31:0] status;
    logic [15:0] run_cyc_q;
    logic        run_clean_q;

    assign cal_sel  = cfg_q[RWCC_CAL_LSB +: 2];
    assign sel_cfg  = (avs_req_i.address == RWCC_CFG_OFFSET);
    assign sel_stat = (avs_req_i.address == RWCC_STAT_OFFSET);

    // Bus wait: one wait cycle, then accept
    assign avs_waitrequest_o = (avs_req_i.read | avs_req_i.write) & ~ack_q;
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_req_i.read | avs_req_i.write) & ~ack_q;
        end
    end

    // Status view
    always_comb begin
        status                            = 32'h0000_0000;
        status[RWCC_ST_RDY_POS]           = ready_q;
        status[RWCC_ST_XON_POS]           = crystal_enable_o;
        status[RWCC_ST_PH_LSB +: 2]       = phase_q;
        status[RWCC_ST_EXP_LSB +: 9]      = expiry_q;
    end

    // Read data, captured during the wait cycle; unmapped reads return zero
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (avs_req_i.read && !ack_q) begin
            rdata_q <= sel_cfg ? {24'h00_0000, cfg_q} : (sel_stat ? status : 32'h0000_0000);
        end
    end
    assign avs_readdata_o = rdata_q;

    // Configuration write on the accepting edge; reserved bits stay zero
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cfg_q <= RWCC_CFG_RESET;
        end else if (avs_req_i.write && ack_q && sel_cfg && avs_req_i.byteenable[0]) begin
            cfg_q <= avs_req_i.writedata[7:0] & RWCC_CFG_MASK;
        end
    end

    // Crystal runs unless asleep without keep-alive
    assign crystal_enable_o = ~sleep_i | cfg_q[RWCC_KEEP_POS];

    // Ripple step generator at crystal-like rate
    assign step = acc_q > (16'hffff - STEP_INC);
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            acc_q <= 16'h0000;
        end else if (!(crystal_enable_o && crystal_oscillator_stable_i)) begin
            acc_q <= 16'h0000;
        end else begin
            acc_q <= acc_q + STEP_INC;
        end
    end

    // Expiry target from timeout field
    always_comb begin
        unique case (cfg_q[RWCC_PO_LSB +: 2])
            2'd0: target = RWCC_EXP_0;
            2'd1: target = RWCC_EXP_1;
            2'd2: target = RWCC_EXP_2;
            2'd3: target = RWCC_EXP_3;
        endcase
    end

    // Six-bit ripple counter and expiry count after crystal is stable
    assign expire = step && (ripple_q == 6'h3f);
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ripple_q <= 6'h00;
            expiry_q <= 9'h000;
        end else if (!(crystal_enable_o && crystal_oscillator_stable_i)) begin
            ripple_q <= 6'h00;
            expiry_q <= 9'h000;
        end else begin
            if (step) begin
                ripple_q <= ripple_q + 6'h01;
            end
            if (expire && !ready_q) begin
                expiry_q <= expiry_q + 9'h001;
            end
        end
    end

    // Ready once enough expiries seen; lost with the crystal
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ready_q <= 1'b0;
        end else if (!(crystal_enable_o && crystal_oscillator_stable_i)) begin
            ready_q <= 1'b0;
        end else if (expiry_q >= target) begin
            ready_q <= 1'b1;
        end
    end
    assign chip_ready_low_o = ~ready_q;

    // Crystal run length and whether config held still, for the timeout window check
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            run_cyc_q   <= 16'h0000;
            run_clean_q <= 1'b1;
        end else if (!(crystal_enable_o && crystal_oscillator_stable_i)) begin
            run_cyc_q   <= 16'h0000;
            run_clean_q <= 1'b1;
        end else begin
            if (run_cyc_q != 16'hffff) begin
                run_cyc_q <= run_cyc_q + 16'h0001;  // Saturates on long timeouts
            end
            if (avs_req_i.write && ack_q && sel_cfg) begin
                run_clean_q <= 1'b0;  // Mid-count change moves the target
            end
        end
    end

    // Calibration decision per schedule
    always_comb begin
        cal_d = cal_strobe_i;
        unique case (cal_sel)
            2'd0: cal_d = cal_strobe_i;
            2'd1: cal_d = cal_strobe_i | idle_to_active_i;
            2'd2: cal_d = cal_strobe_i | auto_idle_i;
            2'd3: cal_d = cal_strobe_i | (auto_idle_i && phase_q == 2'd3);
        endcase
    end

    // Count automatic returns to idle under setting 3
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            phase_q <= 2'd0;
        end else if (cal_sel != 2'd3) begin
            phase_q <= 2'd0;
        end else if (auto_idle_i) begin
            phase_q <= phase_q + 2'd1;
        end
    end

    // Registered calibration start and accepted pin requests
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cal_q <= 1'b0;
            pin_q <= 1'b0;
        end else begin
            cal_q <= cal_d;
            pin_q <= pin_radio_req_i & cfg_q[RWCC_PIN_POS];
        end
    end
    assign fs_cal_start_o  = cal_q;
    assign pin_radio_req_o = pin_q;

    // Checks
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);

    chk_keep_alive_xon: assert property (cfg_q[RWCC_KEEP_POS] |-> crystal_enable_o)
        else $error("crystal stopped with keep-alive set");
    chk_never_auto_cal: assert property ((cal_sel == 2'd0) && !cal_strobe_i |=> !fs_cal_start_o)
        else $error("calibration without strobe in setting 0");
    chk_fourth_return_cal: assert property ((cal_sel == 2'd3) && auto_idle_i && !cal_strobe_i
            && $past(cal_sel) == 2'd3 |=> fs_cal_start_o == ($past(phase_q) == 2'd3))
        else $error("setting 3 calibrated on wrong return");
    chk_phase_wraps: assert property ((cal_sel == 2'd3) && auto_idle_i && phase_q == 2'd3
            ##1 (cal_sel == 2'd3) |-> phase_q == 2'd0)
        else $error("return counter did not wrap after fourth");
    chk_ready_needs_count: assert property ($rose(ready_q) |-> $past(expiry_q) >= $past(target))
        else $error("ready before enough expiries");
    chk_ready_needs_xtal: assert property (ready_q |-> $past(crystal_oscillator_stable_i) && $past(crystal_enable_o))
        else $error("ready without stable crystal");
    chk_expire_map: assert property ((cfg_q[RWCC_PO_LSB +: 2] == 2'd2) |-> target == 9'h040)
        else $error("timeout 2 does not select 64");
    chk_setting2_window: assert property ($rose(ready_q) && run_clean_q && (cfg_q[RWCC_PO_LSB +: 2] == 2'd2)
            && STEP_INC == RWCC_STEP_INC
            |-> run_cyc_q >= 16'(RWCC_T2_MIN_CYC) && run_cyc_q <= 16'(RWCC_T2_MAX_CYC))
        else $error("ready outside the window for timeout 2");
    chk_pin_gate: assert property (pin_radio_req_i |=> pin_radio_req_o == $past(cfg_q[RWCC_PIN_POS]))
        else $error("pin request gating wrong");

endmodule : rwcc_wake_cal

`default_nettype wire

// >>> rwcc_host_model.sv
// Purpose: Host model that times the ready indication after crystal start.
// Assumes: Ready is active low; the host counts reference clock cycles.
// Notes:   Count restarts whenever the crystal is reported unstable.
`default_nettype none
module rwcc_host_model (
    // Clock and reset
    input  wire logic ref_clk_i,
    input  wire logic arst_n_i,
    // Observed pins
    input  wire logic crystal_oscillator_stable_i,
    input  wire logic chip_ready_low_i,
    // Measured delay in cycles
    output var  int   wait_cyc_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Host waits for ready before use, counting the delay
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wait_cyc_o <= 0;
        end else if (!crystal_oscillator_stable_i) begin
            wait_cyc_o <= 0;
        end else if (chip_ready_low_i) begin
            wait_cyc_o <= wait_cyc_o + 1;
        end
    end
endmodule : rwcc_host_model
`default_nettype wire

// >>> radio_wake_calib_config_bench.sv
// Purpose: Self-checking bench for the wake and calibration block.
// Assumes: Fast instance steps the ripple counter every 2 cycles.
// Notes:   Second instance keeps the default step to time setting 2.
`default_nettype none
module radio_wake_calib_config_bench import rwcc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [7:0] wa; logic [7:0] wd; logic [7:0] ra; logic [31:0] ex;} rwcc_row_type;
    localparam rwcc_row_type ROWS [6] = '{'{8'h18, 8'hff, 8'h18, 32'h3f}, '{8'h18, 8'h15, 8'h18, 32'h15},
                                          '{8'h40, 8'h2a, 8'h40, 32'h0}, '{8'h40, 8'h2a, 8'h18, 32'h15},
                                          '{8'h1c, 8'hff, 8'h1c, 32'h2}, '{8'h1c, 8'h00, 8'h18, 32'h15}};
    logic             ref_clk_i = 1'b0;
    logic             arst_n_i  = 1'b0;
    rwcc_avs_req_type req       = '0;
    logic             stable    = 1'b0;
    logic             stable_b  = 1'b0;
    logic             sleep     = 1'b0;
    logic [3:0]       ev        = '0;
    logic [31:0]      rdata, q;
    logic             wreq, xon, rdy_n, rdy_n_b, cal, pin;
    int               wait_cyc, wait_cyc_b, err_total = 0, compares = 0, cycles = 0;

    // Designs and host models
    rwcc_wake_cal #(.STEP_INC(16'h8000)) rwcc_wake_cal_i (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
        .avs_req_i(req), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .crystal_oscillator_stable_i(stable),
        .sleep_i(sleep), .idle_to_active_i(ev[0]), .auto_idle_i(ev[1]), .cal_strobe_i(ev[2]),
        .pin_radio_req_i(ev[3]), .crystal_enable_o(xon), .chip_ready_low_o(rdy_n), .fs_cal_start_o(cal),
        .pin_radio_req_o(pin));
    rwcc_wake_cal rwcc_wake_cal_i2 (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .avs_req_i(req),
        .avs_readdata_o(), .avs_waitrequest_o(), .crystal_oscillator_stable_i(stable_b), .sleep_i(sleep),
        .idle_to_active_i(ev[0]), .auto_idle_i(ev[1]), .cal_strobe_i(ev[2]), .pin_radio_req_i(ev[3]),
        .crystal_enable_o(), .chip_ready_low_o(rdy_n_b), .fs_cal_start_o(), .pin_radio_req_o());
    rwcc_host_model rwcc_host_model_i (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .crystal_oscillator_stable_i(stable),
        .chip_ready_low_i(rdy_n), .wait_cyc_o(wait_cyc));
    rwcc_host_model rwcc_host_model_i2 (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .crystal_oscillator_stable_i(stable_b),
        .chip_ready_low_i(rdy_n_b), .wait_cyc_o(wait_cyc_b));

    // Clock and hang limit
    always #4 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 60000) begin
            err_total++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One Avalon access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        req <= '{read: !wr, write: wr, address: a, writedata: {24'h0, d}, byteenable: 4'hf};
        do begin
            @(posedge ref_clk_i);
        end while (wreq !== 1'b0);
        q = rdata;
        req <= '0;
    endtask : bus

    // One-cycle event pulse, then the registered answers
    task automatic pulse(input int k, input logic [31:0] exp_cal, input logic [31:0] exp_pin);
        @(posedge ref_clk_i);
        ev[k] <= 1'b1;
        @(posedge ref_clk_i);
        ev[k] <= 1'b0;
        @(negedge ref_clk_i);
        check(cal, exp_cal);
        check(pin, exp_pin);
    endtask : pulse

    // Crystal start to ready, n expiries of 128 cycles each
    task automatic start_xtal(input logic [7:0] cfg, input int n);
        bus(1'b1, 8'h18, cfg);
        stable <= 1'b1;
        wait (rdy_n === 1'b0);
        #1;
        check(wait_cyc >= n * 128 - 4 && wait_cyc <= n * 128 + 8, 1);
        @(posedge ref_clk_i);
        stable <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        check(rdy_n, 1'b1);
    endtask : start_xtal

    // Main sequence
    initial begin
        repeat (8) @(posedge ref_clk_i);
        check(rdy_n, 1'b1);
        arst_n_i <= 1'b1;
        bus(1'b0, 8'h18, 8'h00);
        check(q, 32'h04);
        foreach (ROWS[i]) begin
            bus(1'b1, ROWS[i].wa, ROWS[i].wd);
            bus(1'b0, ROWS[i].ra, 8'h00);
            check(q, ROWS[i].ex);
        end
        for (int s = 0; s < 3; s++) begin
            bus(1'b1, 8'h18, 8'(s << 4));
            pulse(0, s == 1, 0);
            pulse(1, s == 2, 0);
            pulse(2, 1, 0);
            pulse(3, 0, 0);
        end
        bus(1'b1, 8'h18, 8'h32);
        for (int i = 0; i < 8; i++) pulse(1, i % 4 == 3, 0);
        pulse(3, 0, 1);
        @(posedge ref_clk_i);
        sleep <= 1'b1;
        @(negedge ref_clk_i);
        check(xon, 1'b0);
        bus(1'b1, 8'h18, 8'h33);
        @(negedge ref_clk_i);
        check(xon, 1'b1);
        @(posedge ref_clk_i);
        sleep <= 1'b0;
        start_xtal(8'h00, 1);
        start_xtal(8'h04, 16);
        bus(1'b1, 8'h18, 8'h09);
        stable_b <= 1'b1;
        sleep    <= 1'b1;
        wait (rdy_n_b === 1'b0);
        #1;
        check(wait_cyc_b >= RWCC_T2_MIN_CYC && wait_cyc_b <= RWCC_T2_MAX_CYC, 1);
        // Mid-run reset: ready lost at once, config back to its reset value
        @(posedge ref_clk_i);
        arst_n_i <= 1'b0;
        @(negedge ref_clk_i);
        check(rdy_n_b, 1'b1);
        repeat (2) @(posedge ref_clk_i);
        arst_n_i <= 1'b1;
        bus(1'b0, 8'h18, 8'h00);
        check(q, 32'h04);
        give_verdict();
    end
endmodule : radio_wake_calib_config_bench
`default_nettype wire
